// ==== verilog/emi_defs.svh ====
`ifndef EMI_DEFS_SVH
`define EMI_DEFS_SVH
// Register indices, byte address is four times the index
`define EMI_OFS_PAGE1 16'hC018
`define EMI_OFS_PAGE2 16'hC01A
`define EMI_OFS_UPGATE 16'hC038
`define EMI_OFS_TIMING 16'hC03A
`define EMI_OFS_DEBUG 16'hC03E
// Field positions
`define EMI_UPGATE_BIT 3
`define EMI_RAM_MERGE_BIT 13
`define EMI_ROM_MERGE_BIT 12
`define EMI_WIN_WIDTH_BIT 11
`define EMI_WIN_WAIT_LSB 8
`define EMI_ROM_WIDTH_BIT 7
`define EMI_ROM_WAIT_LSB 4
`define EMI_RAM_WIDTH_BIT 3
`define EMI_RAM_WAIT_LSB 0
`define EMI_ARB_LSB 8
`define EMI_MON_BIT 0
// Masks of writable bits
`define EMI_UPGATE_MASK 16'h0008
`define EMI_TIMING_MASK 16'h3FFF
`define EMI_DEBUG_MASK 16'h0701
// Reset values
`define EMI_PAGE_RST 16'h0000
`define EMI_UPGATE_RST 16'h0000
`define EMI_TIMING_RST 16'h0000
`define EMI_DEBUG_RST 16'h0000
// Address windows
`define EMI_PAGE1_BASE 16'h8000
`define EMI_PAGE2_BASE 16'hA000
`define EMI_ROM_BASE 16'hC100
`define EMI_RAM_BASE 16'h4000
// Core clock rate
`define EMI_CORE_MHZ 48
`endif

// ==== verilog/emi_pkg.sv ====
package emi_pkg;
	typedef enum logic [1:0] {
		EMI_IDLE,
		EMI_WAIT,
		EMI_DONE
	} emi_state_t;
	typedef enum logic [1:0] {
		EMI_RG_WIN,
		EMI_RG_ROM,
		EMI_RG_RAM
	} emi_region_t;
endpackage

// ==== verilog/emi_arb_throttle.sv ====
`timescale 1ns/100ps
module emi_arb_throttle
	import emi_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Control
	input wire logic [2:0] dead_sel,
	// Status
	output logic avail
);
	typedef struct packed {
		logic [2:0] phase_r;
	} emi_thr_state_t;
	emi_thr_state_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.phase_r = s_r.phase_r + 3'h1;
	end

	assign avail = (s_r.phase_r >= dead_sel);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// ==== verilog/emi_wait_timer.sv ====
`timescale 1ns/100ps
module emi_wait_timer
	import emi_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Control
	input wire logic start,
	input wire logic [2:0] waits,
	// Status
	output logic busy,
	output logic done
);
	typedef struct packed {
		emi_state_t st_r;
		logic [2:0] cnt_r;
	} emi_wt_state_t;
	emi_wt_state_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		case (s_r.st_r)
			EMI_IDLE: begin
				if (start) begin
					s_nxt.cnt_r = waits;
					s_nxt.st_r = (waits == 3'h0) ? EMI_DONE : EMI_WAIT;
				end
			end
			EMI_WAIT: begin
				s_nxt.cnt_r = s_r.cnt_r - 3'h1;
				if (s_r.cnt_r == 3'h1) begin
					s_nxt.st_r = EMI_DONE;
				end
			end
			default: begin
				s_nxt.st_r = EMI_IDLE;
			end
		endcase
	end

	assign busy = (s_r.st_r != EMI_IDLE);
	assign done = (s_r.st_r == EMI_DONE);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_r <= '{st_r: EMI_IDLE, cnt_r: 3'h0};
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// ==== verilog/emi_ctrl.sv ====
// Operation
// - Arbitration code sets dead cycles per eight
// - Monitor bit echoes internal address out
// - Page register bits replace low window address bits
// - Non-SRAM window access shows page bits 8:0
// - SRAM mode uses only page bits 4:0
// - Window access asserts memory select low
// - Bit 3 gates upper lines, reset off
// - Upper lines driven high until enabled
// - Wait states counted in core cycles
// - RAM merge follows memory select
// - ROM merge follows memory select
// - Width bit one eight, zero sixteen
// - Three-bit wait count zero to seven
//
// Decided for this implementation: the APB register port.
`include "emi_defs.svh"
`timescale 1ns/100ps
module emi_ctrl
	import emi_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic NRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [17:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Internal CPU memory port
	input wire logic CPU_REQ,
	input wire logic CPU_WRITE,
	input wire logic [15:0] CPU_ADDR,
	input wire logic SRAM_MODE,
	output logic CPU_ACK,
	output logic MEM_AVAIL,
	// External memory pins
	output logic [18:0] EXT_ADDR,
	output logic EXT_WINDOW_SELECT_N,
	output logic EXT_RAM_SELECT_N,
	output logic EXT_ROM_SELECT_N,
	output logic EXT_RD_N,
	output logic EXT_WR_N,
	output logic EXT_BUS_8BIT
);
	typedef struct packed {
		logic [15:0] page1_r;
		logic [15:0] page2_r;
		logic [15:0] upgate_r;
		logic [15:0] timing_r;
		logic [15:0] debug_r;
		logic [31:0] prdata_r;
		logic [18:0] addr_r;
		logic win_n_r;
		logic ram_n_r;
		logic rom_n_r;
		logic rd_n_r;
		logic wr_n_r;
		logic bus8_r;
		logic active_r;
		emi_region_t region_r;
	} emi_state_all_t;
	emi_state_all_t s_r, s_nxt;

	logic apb_wr;
	logic apb_rd;
	logic avail;
	logic start;
	logic busy;
	logic done;
	logic [2:0] waits;
	logic in_win1;
	logic in_win2;
	logic in_win;
	logic in_rom;
	logic in_ram;
	logic [15:0] page_sel;
	logic [18:0] addr_calc;
	emi_region_t region_calc;
	logic width_calc;

	////////////////////////////////////////////////////////////////////////////////
	// Submodules

	emi_arb_throttle u_thr (
		.clock(CLOCK),
		.nrst(NRST),
		.dead_sel(s_r.debug_r[`EMI_ARB_LSB +: 3]),
		.avail(avail)
	);

	emi_wait_timer u_wait (
		.clock(CLOCK),
		.nrst(NRST),
		.start(start),
		.waits(waits),
		.busy(busy),
		.done(done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode of CPU accesses

	assign in_win1 = ({CPU_ADDR[15:13], 13'h0000} == `EMI_PAGE1_BASE);
	assign in_win2 = ({CPU_ADDR[15:13], 13'h0000} == `EMI_PAGE2_BASE);
	assign in_win = in_win1 | in_win2;
	assign in_rom = !in_win && (CPU_ADDR >= `EMI_ROM_BASE);
	assign in_ram = !in_win && !in_rom && (CPU_ADDR >= `EMI_RAM_BASE);
	assign page_sel = in_win2 ? s_r.page2_r : s_r.page1_r;

	always_comb begin
		addr_calc = {3'h0, CPU_ADDR};
		region_calc = EMI_RG_RAM;
		if (in_win) begin
			region_calc = EMI_RG_WIN;
			addr_calc = {6'h00, CPU_ADDR[12:0]};
			if (SRAM_MODE) begin
				addr_calc[4:0] = page_sel[4:0];
			end else begin
				addr_calc[8:0] = page_sel[8:0];
			end
		end else if (in_rom) begin
			region_calc = EMI_RG_ROM;
		end
	end

	always_comb begin
		waits = s_r.timing_r[`EMI_RAM_WAIT_LSB +: 3];
		width_calc = s_r.timing_r[`EMI_RAM_WIDTH_BIT];
		if (region_calc == EMI_RG_WIN) begin
			waits = s_r.timing_r[`EMI_WIN_WAIT_LSB +: 3];
			width_calc = s_r.timing_r[`EMI_WIN_WIDTH_BIT];
		end else if (region_calc == EMI_RG_ROM) begin
			waits = s_r.timing_r[`EMI_ROM_WAIT_LSB +: 3];
			width_calc = s_r.timing_r[`EMI_ROM_WIDTH_BIT];
		end
	end

	assign start = CPU_REQ && avail && !busy && !s_r.active_r && (in_win | in_rom | in_ram);
	assign apb_wr = PSEL && PENABLE && PWRITE;
	assign apb_rd = PSEL && PENABLE && !PWRITE;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_nxt = s_r;
		// APB writes, reserved bits dropped
		if (apb_wr) begin
			if (PADDR == {`EMI_OFS_PAGE1, 2'b00}) begin
				s_nxt.page1_r = PWDATA[15:0];
			end else if (PADDR == {`EMI_OFS_PAGE2, 2'b00}) begin
				s_nxt.page2_r = PWDATA[15:0];
			end else if (PADDR == {`EMI_OFS_UPGATE, 2'b00}) begin
				s_nxt.upgate_r = PWDATA[15:0] & `EMI_UPGATE_MASK;
			end else if (PADDR == {`EMI_OFS_TIMING, 2'b00}) begin
				s_nxt.timing_r = PWDATA[15:0] & `EMI_TIMING_MASK;
			end else if (PADDR == {`EMI_OFS_DEBUG, 2'b00}) begin
				s_nxt.debug_r = PWDATA[15:0] & `EMI_DEBUG_MASK;
			end
		end
		// APB reads; debug register is write only
		s_nxt.prdata_r = 32'h0000_0000;
		if (PSEL && !PENABLE && !PWRITE) begin
			if (PADDR == {`EMI_OFS_PAGE1, 2'b00}) begin
				s_nxt.prdata_r = {16'h0000, s_r.page1_r};
			end else if (PADDR == {`EMI_OFS_PAGE2, 2'b00}) begin
				s_nxt.prdata_r = {16'h0000, s_r.page2_r};
			end else if (PADDR == {`EMI_OFS_UPGATE, 2'b00}) begin
				s_nxt.prdata_r = {16'h0000, s_r.upgate_r};
			end else if (PADDR == {`EMI_OFS_TIMING, 2'b00}) begin
				s_nxt.prdata_r = {16'h0000, s_r.timing_r};
			end
		end else if (apb_rd) begin
			s_nxt.prdata_r = s_r.prdata_r;
		end
		// External access sequencing
		if (start) begin
			s_nxt.active_r = 1'b1;
			s_nxt.region_r = region_calc;
			s_nxt.addr_r = addr_calc;
			s_nxt.bus8_r = width_calc;
			s_nxt.win_n_r = !(region_calc == EMI_RG_WIN);
			s_nxt.ram_n_r = !((region_calc == EMI_RG_RAM) ||
				(region_calc == EMI_RG_WIN && s_r.timing_r[`EMI_RAM_MERGE_BIT]));
			s_nxt.rom_n_r = !((region_calc == EMI_RG_ROM) ||
				(region_calc == EMI_RG_WIN && s_r.timing_r[`EMI_ROM_MERGE_BIT]));
			s_nxt.rd_n_r = CPU_WRITE;
			s_nxt.wr_n_r = !CPU_WRITE;
		end else if (s_r.active_r && done) begin
			s_nxt.active_r = 1'b0;
			s_nxt.win_n_r = 1'b1;
			s_nxt.ram_n_r = 1'b1;
			s_nxt.rom_n_r = 1'b1;
			s_nxt.rd_n_r = 1'b1;
			s_nxt.wr_n_r = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers and outputs

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			s_r.page1_r <= `EMI_PAGE_RST;
			s_r.page2_r <= `EMI_PAGE_RST;
			s_r.upgate_r <= `EMI_UPGATE_RST;
			s_r.timing_r <= `EMI_TIMING_RST;
			s_r.debug_r <= `EMI_DEBUG_RST;
			s_r.prdata_r <= 32'h0000_0000;
			s_r.addr_r <= 19'h00000;
			s_r.win_n_r <= 1'b1;
			s_r.ram_n_r <= 1'b1;
			s_r.rom_n_r <= 1'b1;
			s_r.rd_n_r <= 1'b1;
			s_r.wr_n_r <= 1'b1;
			s_r.bus8_r <= 1'b0;
			s_r.active_r <= 1'b0;
			s_r.region_r <= EMI_RG_RAM;
		end else begin
			s_r <= s_nxt;
		end
	end

	always_comb begin
		EXT_ADDR = s_r.addr_r;
		if (s_r.debug_r[`EMI_MON_BIT]) begin
			EXT_ADDR = {3'h0, CPU_ADDR};
		end
		// upper lines high while gated off
		if (!s_r.upgate_r[`EMI_UPGATE_BIT]) begin
			EXT_ADDR[18:15] = 4'hF;
		end
	end

	assign PRDATA = s_r.prdata_r;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign CPU_ACK = s_r.active_r && done;
	assign MEM_AVAIL = avail;
	assign EXT_WINDOW_SELECT_N = s_r.win_n_r;
	assign EXT_RAM_SELECT_N = s_r.ram_n_r;
	assign EXT_ROM_SELECT_N = s_r.rom_n_r;
	assign EXT_RD_N = s_r.rd_n_r;
	assign EXT_WR_N = s_r.wr_n_r;
	// width bit one means eight bits
	assign EXT_BUS_8BIT = s_r.bus8_r;
endmodule

// ==== sim/emi_ctrl_asserts.sv ====
`timescale 1ns/100ps
module emi_ctrl_chk (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic NRST,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [17:0] PADDR,
	input wire logic [31:0] PWDATA,
	// CPU side
	input wire logic [15:0] CPU_ADDR,
	input wire logic CPU_ACK,
	input wire logic MEM_AVAIL,
	// Memory pins
	input wire logic [18:0] EXT_ADDR,
	input wire logic EXT_WINDOW_SELECT_N,
	input wire logic EXT_RAM_SELECT_N,
	input wire logic EXT_ROM_SELECT_N,
	input wire logic EXT_RD_N,
	input wire logic EXT_WR_N,
	input wire logic EXT_BUS_8BIT
);
	logic [15:0] tim_r;
	logic [2:0] arb_r;
	logic gate_r;
	logic mon_r;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	// Shadow of written control bits
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			tim_r <= 16'h0000;
			arb_r <= 3'h0;
			gate_r <= 1'b0;
			mon_r <= 1'b0;
		end else if (PSEL && PENABLE && PWRITE) begin
			if (PADDR == 18'h300E8) tim_r <= PWDATA[15:0];
			if (PADDR == 18'h300E0) gate_r <= PWDATA[3];
			if (PADDR == 18'h300F8) arb_r <= PWDATA[10:8];
			if (PADDR == 18'h300F8) mon_r <= PWDATA[0];
		end
	end
	////////////////////////////////////////
	chk_upper_high: assert property (
		!gate_r && !$past(gate_r) && !mon_r && !$past(mon_r) |-> EXT_ADDR[18:15] == 4'hF)
		else $error("upper lines not high");
	chk_mon_echo: assert property (
		mon_r && $past(mon_r) |-> EXT_ADDR[14:0] == CPU_ADDR[14:0])
		else $error("address not echoed");
	chk_ack_strobe: assert property (
		CPU_ACK |-> !(EXT_RD_N && EXT_WR_N)) else $error("ack without strobe");
	chk_strobe_sel: assert property (
		!(EXT_RD_N && EXT_WR_N) |-> !(EXT_WINDOW_SELECT_N && EXT_RAM_SELECT_N && EXT_ROM_SELECT_N))
		else $error("strobe without select");
	chk_ram_merge: assert property (
		!EXT_WINDOW_SELECT_N |-> EXT_RAM_SELECT_N == !tim_r[13]) else $error("ram merge wrong");
	chk_rom_merge: assert property (
		!EXT_WINDOW_SELECT_N |-> EXT_ROM_SELECT_N == !tim_r[12]) else $error("rom merge wrong");
	chk_arb_open: assert property (
		arb_r == 3'h0 && $past(arb_r) == 3'h0 |-> MEM_AVAIL) else $error("cycle blocked");
	chk_win_width: assert property (
		!EXT_WINDOW_SELECT_N |-> EXT_BUS_8BIT == tim_r[11]) else $error("window width wrong");
endmodule
bind emi_ctrl emi_ctrl_chk u_chk (.CLOCK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
	.CPU_ADDR, .CPU_ACK, .MEM_AVAIL, .EXT_ADDR, .EXT_WINDOW_SELECT_N, .EXT_RAM_SELECT_N,
	.EXT_ROM_SELECT_N, .EXT_RD_N, .EXT_WR_N, .EXT_BUS_8BIT);

// ==== sim/emi_ext_mem.sv ====
`timescale 1ns/100ps
module emi_ext_mem (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Strobes
	input wire logic rd_n,
	input wire logic wr_n,
	// Measured strobe length
	output logic [3:0] last_len
);
	logic [3:0] cnt_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 4'h0;
			last_len <= 4'h0;
		end else if (!rd_n || !wr_n) begin
			cnt_r <= cnt_r + 4'h1;
		end else if (cnt_r != 4'h0) begin
			last_len <= cnt_r;
			cnt_r <= 4'h0;
		end
	end
endmodule

// ==== sim/emi_ctrl_tb.sv ====
`timescale 1ns/100ps
module emi_ctrl_tb;
	logic clock, nrst, psel, penable, pwrite, req, cwr, sram, pready, ack, avail;
	logic win_n, ram_n, rom_n, rd_n, wr_n, b8, perr, rerr;
	logic [17:0] paddr;
	logic [15:0] caddr;
	logic [31:0] pwdata, prdata, rd;
	logic [18:0] xa, xs;
	logic [5:0] ps;
	logic [3:0] len;
	int errors = 0;
	int checked = 0;
	emi_ctrl u_dut (.CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
		.CPU_REQ(req), .CPU_WRITE(cwr), .CPU_ADDR(caddr), .SRAM_MODE(sram), .CPU_ACK(ack),
		.MEM_AVAIL(avail), .EXT_ADDR(xa), .EXT_WINDOW_SELECT_N(win_n), .EXT_RAM_SELECT_N(ram_n),
		.EXT_ROM_SELECT_N(rom_n), .EXT_RD_N(rd_n), .EXT_WR_N(wr_n), .EXT_BUS_8BIT(b8));
	emi_ext_mem u_mem (.clock(clock), .nrst(nrst), .rd_n(rd_n), .wr_n(wr_n), .last_len(len));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		rerr = perr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic cpu(input logic [15:0] a, input logic w, input logic [2:0] n, input logic s);
		@(posedge clock);
		req <= 1'b1;
		caddr <= a;
		cwr <= w;
		sram <= s;
		for (int k = 0; k <= n; k++) begin
			@(posedge clock);
			#1;
			chk(ack, k == n);
		end
		// Pins as they stand in the ack cycle
		xs = xa;
		ps = {win_n, ram_n, rom_n, b8, rd_n, wr_n};
		@(posedge clock);
		req <= 1'b0;
	endtask
	task automatic t_regs;
		logic [15:0] a[6] = '{16'hC018, 16'hC01A, 16'hC038, 16'hC03A, 16'hC03E, 16'hC000};
		logic [15:0] v[6] = '{16'hFEFF, 16'h7E55, 16'h0008, 16'h3FFF, 16'h0701, 16'h5A5A};
		logic [15:0] e[6] = '{16'hFEFF, 16'h7E55, 16'h0008, 16'h3FFF, 16'h0000, 16'h0000};
		chk(xa[18:15], 4'hF);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, a[i], 32'h0);
			chk(rd, 32'h0);
			apb(1'b1, a[i], {16'h0, v[i]});
			apb(1'b0, a[i], 32'h0);
			chk(rd, {16'h0, e[i]});
			chk(rerr, 1'b0);
		end
		apb(1'b1, 16'hC03E, 32'h0);
	endtask
	task automatic t_win;
		logic [15:0] pg, ad;
		logic [18:0] e;
		apb(1'b1, 16'hC038, 32'h0);
		apb(1'b1, 16'hC03E, 32'h1);
		@(posedge clock);
		caddr <= 16'h2D6B;
		#1;
		chk(xa[14:0], 15'h2D6B);
		apb(1'b1, 16'hC03E, 32'h0);
		for (int i = 0; i < 8; i++) begin
			pg = i[0] ? 16'h00D5 : 16'h00AA;
			ad = i[0] ? 16'hBC3A : 16'h9E17;
			apb(1'b1, i[0] ? 16'hC01A : 16'hC018, {16'h0, pg});
			apb(1'b1, 16'hC038, i[1] ? 32'h8 : 32'h0);
			apb(1'b1, 16'hC03A, {18'h0, i[0], ~i[0], i[2], i[2:0], 8'h00});
			cpu(ad, i[0], i[2:0], i[1]);
			e = {i[1] ? 4'h0 : 4'hF, 2'h0, ad[12:0]};
			if (i[1]) e[4:0] = pg[4:0];
			else e[8:0] = pg[8:0];
			chk(xs, e);
			chk(ps[5:2], {1'b0, ~i[0], i[0], i[2]});
			chk(ps[1:0], i[0] ? 2'b10 : 2'b01);
			repeat (2) @(posedge clock);
			#1;
			chk(len, i + 1);
		end
		apb(1'b1, 16'hC03A, 32'hD2);
		cpu(16'h4100, 1'b0, 3'd2, 1'b0);
		chk(ps[5:2], 4'b1010);
		cpu(16'hC200, 1'b1, 3'd5, 1'b0);
		chk(ps[5:2], 4'b1101);
		repeat (2) @(posedge clock);
		#1;
		chk(len, 6);
	endtask
	task automatic t_arb;
		int cnt;
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, 16'hC03E, {21'h0, c[2:0], 8'h00});
			@(posedge clock);
			cnt = 0;
			repeat (8) begin
				@(posedge clock);
				#1;
				if (avail === 1'b1) cnt++;
			end
			chk(cnt, 8 - c);
		end
		apb(1'b1, 16'hC03E, 32'h0);
	endtask
	initial begin
		{nrst, psel, penable, pwrite, req, cwr, sram} = 7'h00;
		paddr = 18'h00000;
		pwdata = 32'h0;
		caddr = 16'h0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		#1;
		t_regs;
		t_win;
		t_arb;
		close_out;
	end
	initial begin
		#250000;
		errors++;
		close_out;
	end
endmodule
